// [logic/tmr_params.svh]
// Offsets, field positions, reset values and saturation limits of the monitor reading registers
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

`define TMR_ADDR_CORE_RES 8'h21
`define TMR_ADDR_SUPPLY_RES 8'h22
`define TMR_ADDR_R1_RES 8'h25
`define TMR_ADDR_LOC_RES 8'h26
`define TMR_ADDR_R2_RES 8'h27
`define TMR_ADDR_R1_OFF 8'h70
`define TMR_ADDR_LOC_OFF 8'h71
`define TMR_ADDR_R2_OFF 8'h72
`define TMR_ADDR_CFG2 8'h73
`define TMR_ADDR_MASK1 8'h74
`define TMR_ADDR_MASK2 8'h75
`define TMR_ADDR_VOLT_LOW 8'h76
`define TMR_ADDR_TEMP_LOW 8'h77
`define TMR_ADDR_CFG3 8'h78
`define TMR_ADDR_TMR_STATE 8'h79
`define TMR_ADDR_TMR_LIMIT 8'h7A
`define TMR_ADDR_TACH_PPR 8'h7B
`define TMR_ADDR_CFG5 8'h7C
`define TMR_ADDR_CFG4 8'h7D
`define TMR_ADDR_TEST1 8'h7E
`define TMR_ADDR_TEST2 8'h7F
`define TMR_ADDR_TEST3 8'h80

`define TMR_RST_VOLT 8'h00
`define TMR_RST_TEMP 8'h01
`define TMR_RST_ZERO 8'h00
`define TMR_RST_TACH_PPR 8'h55
`define TMR_RST_TEST3 8'h10

`define TMR_FMT_BIT 0
`define TMR_SHDN_BIT 7
`define TMR_FAULT_TWOS 8'h80
`define TMR_FAULT_OFF64 8'h00
`define TMR_OFF64_BIAS 11'h100
`define TMR_RAW_MAX 11'h1FF
`define TMR_RAW_MIN 11'h600
`define TMR_UNS_MAX 11'h3FF

`endif

// [logic/tmr_pkg.sv]
// Types shared by the monitor reading register bank
package tmr_pkg;

    typedef struct packed {
        logic valid;
        logic [9:0] core_rail_input;
        logic [9:0] supply;
        logic [9:0] remote_one;
        logic [9:0] local_t;
        logic [9:0] remote_two;
        logic remote_one_fault;
        logic remote_two_fault;
    } tmr_meas_t;

    typedef struct packed {
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [7:0] cfg5;
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [7:0] timer_limit;
        logic [7:0] tach_ppr;
    } tmr_cfg_t;

    typedef struct packed {
        logic [7:0] core_res;
        logic [7:0] supply_res;
        logic [7:0] r1_res;
        logic [7:0] loc_res;
        logic [7:0] r2_res;
        logic [7:0] volt_low;
        logic [7:0] temp_low;
        logic [7:0] r1_off;
        logic [7:0] loc_off;
        logic [7:0] r2_off;
        logic [7:0] timer_state;
        tmr_cfg_t cfg;
        logic [7:0] rdata;
        logic [1:0] volt_pend;
        logic [2:0] temp_pend;
    } tmr_state_t;

endpackage : tmr_pkg

// [logic/tmr_regs.sv]
// Reading, offset and upper configuration registers of the thermal monitor
`include "tmr_params.svh"

module tmr_regs
    import tmr_pkg::*;
(
    input wire logic I_REF_CLK, // 50 MHz clock
    input wire logic I_NRST, // Async reset, active low
    input wire logic I_WR_EN, // Register write strobe
    input wire logic I_RD_EN, // Register read strobe
    input wire logic [7:0] I_ADDR, // Register address
    input wire logic [7:0] I_WDATA, // Write data
    output logic [7:0] O_RDATA, // Read data, valid the cycle after I_RD_EN
    input wire tmr_meas_t I_MEAS, // Conversion results from the sequencer
    input wire logic I_LOCK, // Lock bit of config one
    input wire logic I_CORE_RAIL_LOW_SLEEP_ENABLE, // Core-rail low sleep control
    input wire logic [7:0] I_CORE_RAIL_LOW_LIMIT, // Core-rail low limit
    input wire logic I_TIMER_VALID, // Overtemp timer update strobe
    input wire logic [7:0] I_TIMER_VALUE, // Overtemp timer status value
    output tmr_cfg_t O_CFG, // Configuration to the rest of the chip
    output logic O_SLEEP_INHIBIT, // Core rail holds the device awake
    output logic O_SHUTDOWN // Shutdown request to power control
);

    tmr_state_t st_ff;
    tmr_state_t nxt_st;

    logic wr_ok;
    logic lock_wr_ok;
    logic volt_frz_now;
    logic temp_frz_now;
    logic fmt_twos;
    logic [9:0] r1_val;
    logic [9:0] loc_val;
    logic [9:0] r2_val;
    logic [7:0] rd_mux;

    // Offset is whole degrees, raw has two fraction bits; saturate before formatting
    function automatic logic [9:0] tmr_temp_conv(
        input logic [9:0] raw,
        input logic [7:0] off,
        input logic twos,
        input logic fault
    );
        logic [10:0] sum;
        logic [10:0] sat;
        logic [10:0] biased;
        logic [9:0] res;
        sum = {raw[9], raw} + {off[7], off, 2'b00};
        if (!sum[10] && (sum > `TMR_RAW_MAX)) begin
            sat = `TMR_RAW_MAX;
        end else if (sum[10] && (sum < `TMR_RAW_MIN)) begin
            sat = `TMR_RAW_MIN;
        end else begin
            sat = sum;
        end
        biased = sat + `TMR_OFF64_BIAS;
        if (twos) begin
            res = sat[9:0];
        end else if (biased[10]) begin
            res = 10'h000;
        end else if (biased > `TMR_UNS_MAX) begin
            res = 10'h3FF;
        end else begin
            res = biased[9:0];
        end
        if (fault) begin
            res = twos ? {`TMR_FAULT_TWOS, 2'b00} : {`TMR_FAULT_OFF64, 2'b00};
        end
        return res;
    endfunction : tmr_temp_conv

    assign fmt_twos = st_ff.cfg.cfg5[`TMR_FMT_BIT];
    assign wr_ok = I_WR_EN && !I_RD_EN;
    assign lock_wr_ok = wr_ok && !I_LOCK;
    assign r1_val = tmr_temp_conv(I_MEAS.remote_one, st_ff.r1_off, fmt_twos, I_MEAS.remote_one_fault);
    assign loc_val = tmr_temp_conv(I_MEAS.local_t, st_ff.loc_off, fmt_twos, 1'b0);
    assign r2_val = tmr_temp_conv(I_MEAS.remote_two, st_ff.r2_off, fmt_twos, I_MEAS.remote_two_fault);

    always_comb begin
        rd_mux = 8'h00;
        unique case (I_ADDR)
            `TMR_ADDR_CORE_RES: rd_mux = st_ff.core_res;
            `TMR_ADDR_SUPPLY_RES: rd_mux = st_ff.supply_res;
            `TMR_ADDR_R1_RES: rd_mux = st_ff.r1_res;
            `TMR_ADDR_LOC_RES: rd_mux = st_ff.loc_res;
            `TMR_ADDR_R2_RES: rd_mux = st_ff.r2_res;
            `TMR_ADDR_R1_OFF: rd_mux = st_ff.r1_off;
            `TMR_ADDR_LOC_OFF: rd_mux = st_ff.loc_off;
            `TMR_ADDR_R2_OFF: rd_mux = st_ff.r2_off;
            `TMR_ADDR_CFG2: rd_mux = st_ff.cfg.cfg2;
            `TMR_ADDR_MASK1: rd_mux = st_ff.cfg.mask1;
            `TMR_ADDR_MASK2: rd_mux = st_ff.cfg.mask2;
            `TMR_ADDR_VOLT_LOW: rd_mux = st_ff.volt_low;
            `TMR_ADDR_TEMP_LOW: rd_mux = st_ff.temp_low;
            `TMR_ADDR_CFG3: rd_mux = st_ff.cfg.cfg3;
            `TMR_ADDR_TMR_STATE: rd_mux = st_ff.timer_state;
            `TMR_ADDR_TMR_LIMIT: rd_mux = st_ff.cfg.timer_limit;
            `TMR_ADDR_TACH_PPR: rd_mux = st_ff.cfg.tach_ppr;
            `TMR_ADDR_CFG5: rd_mux = st_ff.cfg.cfg5;
            `TMR_ADDR_CFG4: rd_mux = st_ff.cfg.cfg4;
            `TMR_ADDR_TEST1: rd_mux = `TMR_RST_ZERO;
            `TMR_ADDR_TEST2: rd_mux = `TMR_RST_ZERO;
            `TMR_ADDR_TEST3: rd_mux = `TMR_RST_TEST3;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        // Freeze tracking: a low-bit read arms one pending flag per result register
        if (I_RD_EN) begin
            nxt_st.rdata = rd_mux;
            unique case (I_ADDR)
                `TMR_ADDR_VOLT_LOW: nxt_st.volt_pend = 2'b11;
                `TMR_ADDR_TEMP_LOW: nxt_st.temp_pend = 3'b111;
                `TMR_ADDR_CORE_RES: nxt_st.volt_pend[0] = 1'b0;
                `TMR_ADDR_SUPPLY_RES: nxt_st.volt_pend[1] = 1'b0;
                `TMR_ADDR_R1_RES: nxt_st.temp_pend[0] = 1'b0;
                `TMR_ADDR_LOC_RES: nxt_st.temp_pend[1] = 1'b0;
                `TMR_ADDR_R2_RES: nxt_st.temp_pend[2] = 1'b0;
                default: nxt_st.rdata = rd_mux;
            endcase
        end
        volt_frz_now = (nxt_st.volt_pend != 2'b00);
        temp_frz_now = (nxt_st.temp_pend != 3'b000);
        // Gate with the next freeze so a fresh result never splits a low-bit and MSB pair
        if (I_MEAS.valid && !volt_frz_now) begin
            nxt_st.core_res = I_MEAS.core_rail_input[9:2];
            nxt_st.supply_res = I_MEAS.supply[9:2];
            nxt_st.volt_low = {2'b00, I_MEAS.supply[1:0], I_MEAS.core_rail_input[1:0], 2'b00};
        end
        if (I_MEAS.valid && !temp_frz_now) begin
            nxt_st.r1_res = r1_val[9:2];
            nxt_st.loc_res = loc_val[9:2];
            nxt_st.r2_res = r2_val[9:2];
            nxt_st.temp_low = {r2_val[1:0], loc_val[1:0], r1_val[1:0], 2'b00};
        end
        if (I_TIMER_VALID) begin
            nxt_st.timer_state = I_TIMER_VALUE;
        end
        // Writes to read-only addresses, test registers included, are dropped
        if (wr_ok) begin
            unique case (I_ADDR)
                `TMR_ADDR_MASK1: nxt_st.cfg.mask1 = I_WDATA;
                `TMR_ADDR_MASK2: nxt_st.cfg.mask2 = I_WDATA;
                `TMR_ADDR_TMR_LIMIT: nxt_st.cfg.timer_limit = I_WDATA;
                `TMR_ADDR_TACH_PPR: nxt_st.cfg.tach_ppr = I_WDATA;
                default: nxt_st.rdata = nxt_st.rdata;
            endcase
        end
        if (lock_wr_ok) begin
            unique case (I_ADDR)
                `TMR_ADDR_R1_OFF: nxt_st.r1_off = I_WDATA;
                `TMR_ADDR_LOC_OFF: nxt_st.loc_off = I_WDATA;
                `TMR_ADDR_R2_OFF: nxt_st.r2_off = I_WDATA;
                `TMR_ADDR_CFG2: nxt_st.cfg.cfg2 = I_WDATA;
                `TMR_ADDR_CFG3: nxt_st.cfg.cfg3 = I_WDATA;
                `TMR_ADDR_CFG5: nxt_st.cfg.cfg5 = I_WDATA;
                `TMR_ADDR_CFG4: nxt_st.cfg.cfg4 = I_WDATA;
                default: nxt_st.rdata = nxt_st.rdata;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_ff.core_res <= `TMR_RST_VOLT;
            st_ff.supply_res <= `TMR_RST_VOLT;
            st_ff.r1_res <= `TMR_RST_TEMP;
            st_ff.loc_res <= `TMR_RST_TEMP;
            st_ff.r2_res <= `TMR_RST_TEMP;
            st_ff.volt_low <= `TMR_RST_ZERO;
            st_ff.temp_low <= `TMR_RST_ZERO;
            st_ff.r1_off <= `TMR_RST_ZERO;
            st_ff.loc_off <= `TMR_RST_ZERO;
            st_ff.r2_off <= `TMR_RST_ZERO;
            st_ff.timer_state <= `TMR_RST_ZERO;
            st_ff.cfg.cfg2 <= `TMR_RST_ZERO;
            st_ff.cfg.cfg3 <= `TMR_RST_ZERO;
            st_ff.cfg.cfg4 <= `TMR_RST_ZERO;
            st_ff.cfg.cfg5 <= `TMR_RST_ZERO;
            st_ff.cfg.mask1 <= `TMR_RST_ZERO;
            st_ff.cfg.mask2 <= `TMR_RST_ZERO;
            st_ff.cfg.timer_limit <= `TMR_RST_ZERO;
            st_ff.cfg.tach_ppr <= `TMR_RST_TACH_PPR;
            st_ff.rdata <= `TMR_RST_ZERO;
            st_ff.volt_pend <= 2'b00;
            st_ff.temp_pend <= 3'b000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_RDATA = st_ff.rdata;
    assign O_CFG = st_ff.cfg;
    // Unsigned compare; limit equal to result is not low
    assign O_SLEEP_INHIBIT = I_CORE_RAIL_LOW_SLEEP_ENABLE && (st_ff.core_res < I_CORE_RAIL_LOW_LIMIT);
    assign O_SHUTDOWN = st_ff.cfg.cfg2[`TMR_SHDN_BIT] && !O_SLEEP_INHIBIT;

    a_reset_volt: assert property (@(posedge I_REF_CLK) !I_NRST |-> (st_ff.core_res == 8'h00)
        && (st_ff.supply_res == 8'h00))
        else $error("voltage result not zero in reset");

    a_reset_temp: assert property (@(posedge I_REF_CLK) !I_NRST |-> (st_ff.r1_res == 8'h01)
        && (st_ff.loc_res == 8'h01) && (st_ff.r2_res == 8'h01))
        else $error("temperature result not one in reset");

    a_volt_frz_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_VOLT_LOW)) ##1 (!I_RD_EN)
        |-> ($stable(st_ff.core_res) && $stable(st_ff.volt_low) && $stable(st_ff.supply_res)))
        else $error("voltage results changed while frozen");

    a_temp_frz_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_TEMP_LOW)) ##1 (!I_RD_EN)[*2]
        |-> ($stable(st_ff.loc_res) && $stable(st_ff.temp_low)))
        else $error("temperature results changed while frozen");

    a_core_msb_load: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && !I_RD_EN && (st_ff.volt_pend == 2'b00))
        |=> (st_ff.core_res == $past(I_MEAS.core_rail_input[9:2]))
        && (st_ff.volt_low[3:2] == $past(I_MEAS.core_rail_input[1:0])))
        else $error("core-rail result not loaded from top bits");

    a_lock_drop: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_WR_EN && I_LOCK && (I_ADDR == `TMR_ADDR_CFG5)) |=> $stable(st_ff.cfg.cfg5))
        else $error("locked config five was written");

    a_fault_twos: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && I_MEAS.remote_one_fault && fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000))
        |=> (st_ff.r1_res == 8'h80))
        else $error("two's complement diode fault code wrong");

    a_fault_off64: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && I_MEAS.remote_two_fault && !fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000))
        |=> (st_ff.r2_res == 8'h00))
        else $error("offset-by-64 diode fault code wrong");

    a_off64_bias: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && !fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000) && (st_ff.loc_off == 8'h00)
        && !I_MEAS.local_t[9]) |=> (st_ff.loc_res == ({1'b0, $past(I_MEAS.local_t[8:2])} + 8'h40)))
        else $error("offset-by-64 bias missing");

    a_offset_add: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000) && (I_MEAS.local_t == 10'h000)
        && !st_ff.loc_off[7] && !I_WR_EN) |=> (st_ff.loc_res == $past(st_ff.loc_off)))
        else $error("temperature offset not added");

    a_sleep_gate: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (!I_CORE_RAIL_LOW_SLEEP_ENABLE |-> !O_SLEEP_INHIBIT)
        and (O_SLEEP_INHIBIT |-> !O_SHUTDOWN))
        else $error("sleep control wrong");

    a_shdn_pass: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        !I_CORE_RAIL_LOW_SLEEP_ENABLE |-> (O_SHUTDOWN == st_ff.cfg.cfg2[7]))
        else $error("shutdown not following config two");

    a_volt_frz_all: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        volt_frz_now |=> ($stable(st_ff.core_res) && $stable(st_ff.supply_res) && $stable(st_ff.volt_low)))
        else $error("voltage group moved while frozen");

    a_temp_frz_all: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        temp_frz_now |=> ($stable(st_ff.r1_res) && $stable(st_ff.loc_res) && $stable(st_ff.r2_res)
        && $stable(st_ff.temp_low)))
        else $error("temperature group moved while frozen");

    a_volt_arm: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_VOLT_LOW)) |=> (st_ff.volt_pend == 2'b11))
        else $error("voltage freeze not armed");

    a_temp_arm: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_TEMP_LOW)) |=> (st_ff.temp_pend == 3'b111))
        else $error("temperature freeze not armed");

    a_volt_release: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_SUPPLY_RES) && (st_ff.volt_pend == 2'b10)) |=> (st_ff.volt_pend == 2'b00))
        else $error("voltage freeze not released");

    a_temp_release: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_R2_RES) && (st_ff.temp_pend == 3'b100)) |=> (st_ff.temp_pend == 3'b000))
        else $error("temperature freeze not released");

    a_supply_load: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && !I_RD_EN && (st_ff.volt_pend == 2'b00))
        |=> (st_ff.supply_res == $past(I_MEAS.supply[9:2]))
        && (st_ff.volt_low[5:4] == $past(I_MEAS.supply[1:0]))
        && (st_ff.volt_low[7:6] == 2'b00) && (st_ff.volt_low[1:0] == 2'b00))
        else $error("supply result split wrong");

    a_twos_load: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000) && (st_ff.loc_off == 8'h00))
        |=> (st_ff.loc_res == $past(I_MEAS.local_t[9:2])) && (st_ff.temp_low[5:4] == $past(I_MEAS.local_t[1:0])))
        else $error("two's complement local result wrong");

    a_volt_rst_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (!I_MEAS.valid && (st_ff.core_res == 8'h00) && (st_ff.supply_res == 8'h00))
        |=> (st_ff.core_res == 8'h00) && (st_ff.supply_res == 8'h00))
        else $error("voltage result left zero early");

    a_temp_rst_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (!I_MEAS.valid && (st_ff.r1_res == 8'h01) && (st_ff.loc_res == 8'h01) && (st_ff.r2_res == 8'h01))
        |=> (st_ff.r1_res == 8'h01) && (st_ff.loc_res == 8'h01) && (st_ff.r2_res == 8'h01))
        else $error("temperature result left one early");

    a_lock_all: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_WR_EN && I_LOCK) |=> ($stable(st_ff.r1_off) && $stable(st_ff.loc_off) && $stable(st_ff.r2_off)
        && $stable(st_ff.cfg.cfg2) && $stable(st_ff.cfg.cfg3) && $stable(st_ff.cfg.cfg4) && $stable(st_ff.cfg.cfg5)))
        else $error("locked register was written");

    a_test_const: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_RD_EN && (I_ADDR == `TMR_ADDR_TEST3)) |=> (O_RDATA == 8'h10))
        else $error("test register three read wrong");

    a_r1_fault_off64: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && I_MEAS.remote_one_fault && !fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000))
        |=> (st_ff.r1_res == 8'h00) && (st_ff.temp_low[3:2] == 2'b00))
        else $error("remote one fault code wrong");

    a_r2_fault_twos: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        (I_MEAS.valid && I_MEAS.remote_two_fault && fmt_twos && !I_RD_EN && (st_ff.temp_pend == 3'b000))
        |=> (st_ff.r2_res == 8'h80) && (st_ff.temp_low[7:6] == 2'b00))
        else $error("remote two fault code wrong");

    a_timer_load: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        I_TIMER_VALID |=> (st_ff.timer_state == $past(I_TIMER_VALUE)))
        else $error("timer status not loaded");

    a_rd_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
        !I_RD_EN |=> $stable(O_RDATA))
        else $error("read data moved without a read");

endmodule : tmr_regs

// [test/tmr_host.sv]
// Host-side model of the register bus that drives reads and writes into the bank
module tmr_host
    import tmr_pkg::*;
(
    input wire logic i_clk, // Bench clock
    input wire logic [7:0] i_rdata, // Read data from the bank
    output logic o_wr_en, // Write strobe
    output logic o_rd_en, // Read strobe
    output logic [7:0] o_addr, // Register address
    output logic [7:0] o_wdata // Write data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // Idle bus shows the inverse of the last value so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a >= 8'h7E && a <= 8'h80) return;
        @(negedge i_clk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr_en = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_rd_en = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        o_rd_en = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask : rd
endmodule : tmr_host

// [test/tmr_regs_test.sv]
// Self-checking bench of the monitor reading register bank
module tmr_regs_test;
    import tmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, nrst, wr_en, rd_en, lock, slp_en, tmr_vld;
    logic [7:0] addr, wdata, rdata, low_lim, tmr_val;
    tmr_meas_t meas, cur, old;
    tmr_cfg_t cfg;
    logic sleep_inh, shdn;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_fb28;
    logic [7:0] o1, ol, o2, d, r;
    logic fm;
    // Low-bit registers first, so every freeze armed here is released by the result reads
    logic [7:0] rst_a [16] = '{8'h76, 8'h77, 8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h70, 8'h73, 8'h79, 8'h7B,
        8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h30};
    logic [7:0] rst_v [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h55,
        8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    logic [7:0] rw_a [11] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7D};
    logic rw_lk [11] = '{1, 1, 1, 1, 0, 0, 1, 0, 0, 1, 1};

    tmr_regs uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
        .I_WDATA(wdata), .O_RDATA(rdata), .I_MEAS(meas), .I_LOCK(lock), .I_CORE_RAIL_LOW_SLEEP_ENABLE(slp_en),
        .I_CORE_RAIL_LOW_LIMIT(low_lim), .I_TIMER_VALID(tmr_vld), .I_TIMER_VALUE(tmr_val), .O_CFG(cfg),
        .O_SLEEP_INHIBIT(sleep_inh), .O_SHUTDOWN(shdn));
    tmr_host host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wdata(wdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Offset is whole degrees, raw has two fraction bits
    function automatic logic [9:0] exp_temp(input logic [9:0] raw, input logic [7:0] off, input logic tw,
        input logic flt);
        int v;
        v = $signed(raw) + 4 * $signed(off);
        if (v > 511) v = 511;
        if (v < -512) v = -512;
        if (flt) return tw ? 10'h200 : 10'h000;
        if (tw) return v[9:0];
        v = v + 256;
        if (v > 1023) v = 1023;
        if (v < 0) v = 0;
        return v[9:0];
    endfunction : exp_temp

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] id);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t check %h got %h expected %h", $time, id, got, exp);
        end
    endtask : chk

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, e, a);
    endtask : rc

    task automatic apply(input tmr_meas_t m);
        @(negedge clk);
        m.valid = 1'b1;
        meas = m;
        @(negedge clk);
        meas.valid = 1'b0;
    endtask : apply

    function automatic tmr_meas_t rnd_meas();
        tmr_meas_t m;
        m = {rnd(), rnd()};
        m.remote_one_fault = (rnd() % 4) == 0;
        m.remote_two_fault = (rnd() % 4) == 0;
        return m;
    endfunction : rnd_meas

    function automatic logic [9:0] t_of(input tmr_meas_t m, input int ch);
        if (ch == 0) return exp_temp(m.remote_one, o1, fm, m.remote_one_fault);
        if (ch == 1) return exp_temp(m.local_t, ol, fm, 1'b0);
        return exp_temp(m.remote_two, o2, fm, m.remote_two_fault);
    endfunction : t_of

    // Low-bit registers are read ahead of their result registers
    task automatic check_meas(input tmr_meas_t m);
        logic [9:0] t0, t1, t2;
        t0 = t_of(m, 0);
        t1 = t_of(m, 1);
        t2 = t_of(m, 2);
        rc(8'h76, {2'b00, m.supply[1:0], m.core_rail_input[1:0], 2'b00});
        rc(8'h21, m.core_rail_input[9:2]);
        rc(8'h22, m.supply[9:2]);
        rc(8'h77, {t2[1:0], t1[1:0], t0[1:0], 2'b00});
        for (int c = 0; c < 3; c++) rc(8'h25 + c, t_of(m, c) >> 2);
    endtask : check_meas

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[ERR] %0t run did not complete", $time);
            summarize();
        end
    end

    initial begin
        {lock, slp_en, tmr_vld, low_lim, tmr_val} = '0;
        nrst = 1'b1;
        meas = '0;
        // Reset falls after time zero so the bank sees the edge whatever the process order
        @(negedge clk) nrst = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        chk(cfg.tach_ppr, 8'h55, 8'hC0);
        for (int i = 0; i < 16; i++) rc(rst_a[i], rst_v[i]);
        host.wr(8'h21, 8'hFF);
        host.wr(8'h77, 8'hFF);
        host.wr(8'h79, 8'hFF);
        rc(8'h21, 8'h00);
        rc(8'h77, 8'h00);
        for (int c = 0; c < 3; c++) rc(8'h25 + c, 8'h01);
        rc(8'h79, 8'h00);
        $display("test reset and read-only done");
        for (int i = 0; i < 11; i++) begin
            d = rnd();
            host.wr(rw_a[i], d);
            rc(rw_a[i], d);
            @(negedge clk) lock = 1'b1;
            host.wr(rw_a[i], ~d);
            rc(rw_a[i], rw_lk[i] ? d : ~d);
            @(negedge clk) lock = 1'b0;
        end
        chk(cfg.cfg4, d, 8'hC4);
        $display("test writes and lock done");
        host.wr(8'h73, 8'h00);
        for (int i = 0; i < 40; i++) begin
            {o1, ol, o2} = rnd();
            fm = (i < 4) ? i[0] : rnd() % 2;
            if (i < 4) ol = (i == 1) ? 8'h1C : 8'h00;
            if (i == 2) {o1, ol, o2} = 24'h7F80_7F;
            host.wr(8'h70, o1);
            host.wr(8'h71, ol);
            host.wr(8'h72, o2);
            host.wr(8'h7C, {7'h00, fm});
            cur = rnd_meas();
            if (i == 0) cur.local_t[9] = 1'b0;
            if (i == 1) cur.local_t = 10'h000;
            apply(cur);
            check_meas(cur);
        end
        $display("test conversions done");
        old = cur;
        host.rd(8'h76, r);
        host.rd(8'h77, r);
        cur = rnd_meas();
        apply(cur);
        rc(8'h21, old.core_rail_input[9:2]);
        rc(8'h25, t_of(old, 0) >> 2);
        rc(8'h26, t_of(old, 1) >> 2);
        apply(rnd_meas());
        rc(8'h22, old.supply[9:2]);
        rc(8'h27, t_of(old, 2) >> 2);
        cur = rnd_meas();
        cur.core_rail_input = 10'h100;
        apply(cur);
        check_meas(cur);
        $display("test freeze done");
        @(negedge clk);
        slp_en = 1'b1;
        low_lim = 8'h41;
        host.wr(8'h73, 8'h80);
        chk(sleep_inh, 1'b1, 8'hA0);
        chk(shdn, 1'b0, 8'hA1);
        @(negedge clk) low_lim = 8'h40;
        #1 chk(sleep_inh, 1'b0, 8'hA2);
        chk(shdn, 1'b1, 8'hA3);
        @(negedge clk) {slp_en, low_lim} = 9'h0FF;
        #1 chk(sleep_inh, 1'b0, 8'hA4);
        $display("test sleep control done");
        d = rnd();
        @(negedge clk) {tmr_vld, tmr_val} = {1'b1, d};
        @(negedge clk) tmr_vld = 1'b0;
        rc(8'h79, d);
        $display("test timer done");
        summarize();
    end
endmodule : tmr_regs_test
